// ===== rtl/mcid_defs.svh
// Register offsets, field positions, reset values and event codes
`ifndef MCID_DEFS_SVH
`define MCID_DEFS_SVH

// Byte offsets of the device registers, one aligned word each
`define MCID_OFS_PORT_EN     6'h00
`define MCID_OFS_THERM_EN    6'h04
`define MCID_OFS_REQ_SET     6'h08
`define MCID_OFS_REQ_CLR     6'h0C
`define MCID_OFS_PRIO_SET    6'h10
`define MCID_OFS_PRIO_CLR    6'h14
`define MCID_OFS_PIN_DIST    6'h18
`define MCID_OFS_LVL_DIST    6'h1C
`define MCID_OFS_ACK_FLAG    6'h20
`define MCID_OFS_ACK_CLR     6'h24
`define MCID_OFS_ACK_MASK    6'h28
`define MCID_OFS_SRC_STAT    6'h2C

// Field positions
`define MCID_PORT_EN_MSB     7
`define MCID_THERM_EN_MSB    3
`define MCID_PIN_DIST_LSB    24
`define MCID_LVL_DISTRIBUTE_LINE0_BIT   31
`define MCID_LVL_DIST1_BIT   30
`define MCID_STAT_LO_BIT     9
`define MCID_STAT_HI_BIT     10
`define MCID_EVT_MSB         13
`define MCID_FIELD_W         4

// Reset values
`define MCID_RST_WORD        32'h0000_0000

// Event codes of the distributable sources
`define MCID_EVT_PIN_BASE    14'h0240
`define MCID_EVT_LVL_BASE    14'h0340
`define MCID_EVT_STEP        14'h0020

// AXI4-Lite: bit 7 of the byte address picks the CPU
`define MCID_AXI_CPU_BIT     7
`define MCID_RESP_OKAY       2'h0
`define MCID_RESP_SLVERR     2'h2

`endif

// ===== rtl/mcid_pkg.sv
// Types shared by both ends of the interrupt enable and distribution block
package mcid_pkg;
	typedef logic [31:0] mcid_word_t;
	typedef logic [13:0] mcid_evt_t;
	typedef enum logic [4:0] {
		MCID_IDLE = 5'h01,
		MCID_WR   = 5'h02,
		MCID_BRSP = 5'h04,
		MCID_RD   = 5'h08,
		MCID_RRSP = 5'h10
	} mcid_state_t;
endpackage

// ===== rtl/mcid_if.sv
// Register port between the bus-side controller and the interrupt block
`timescale 1ns/1ps
`default_nettype none
interface mcid_if;
	logic                 req;
	logic                 wr;
	logic                 cpu;
	logic [5:0]           addr;
	mcid_pkg::mcid_word_t wdata;
	logic                 ack;
	logic                 err;
	mcid_pkg::mcid_word_t rdata;

	modport dev (input req, wr, cpu, addr, wdata, output ack, err, rdata);
	modport ctl (output req, wr, cpu, addr, wdata, input ack, err, rdata);
endinterface
`default_nettype wire

// ===== rtl/mcid_device.sv
// Interrupt enables, cross-CPU requests and automatic distribution
//
// How it works
// - Port enable bits 7..0 pass inputs
// - Port interrupt inputs are active low
// - Software sets port pins as inputs first
// - Enable effective before the read-back completes
// - Request needs block enable and module mask
// - Port flag reported at status bits 10,9
// - Thermal enable bits 3..0, rest reserved
// - Each 4-bit request field ORs into one
// - Request write: 1 sets, 0 keeps
// - Request and priority registers reset zero
// - Request clear: 1 clears, reads zero
// - Priority write: 1 sets, 0 keeps
// - Priority clear: 1 clears, reads zero
// - Bits 31..24 distribute the eight pins
// - Bits 31,30 distribute level inputs 0,1
// - One CPU wins, source masked everywhere
// - Mask holds until event code written
// - Reserved bits read zero
// - Ack flag one for winner or fixed
// - Ack clear takes 14-bit event code
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "mcid_defs.svh"
module mcid_device (
	input  wire logic              clk,
	input  wire logic              rst_n,
	mcid_if.dev                    bus,
	input  wire logic [7:0]        port_irq_n,
	input  wire logic [7:0]        port_module_mask,
	input  wire logic [3:0]        thermal_irq,
	input  wire logic [3:0]        thermal_module_mask,
	input  wire logic [7:0]        irq_pin,
	input  wire logic [1:0]        level_req,
	input  wire logic [1:0]        cpu_ack_valid,
	input  wire logic [1:0][3:0]   cpu_ack_src,
	output logic [7:0]             port_req,
	output logic [3:0]             thermal_req,
	output logic [1:0][1:0]        port_src_flag,
	output logic [1:0][7:0]        xcpu_irq,
	output logic [1:0][31:0]       xcpu_prio,
	output logic [1:0][9:0]        dist_irq,
	output logic [1:0]             ack_winner_flag
);
	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	logic [7:0]       port_irq_enable;
	logic [3:0]       thermal_irq_enable;
	logic [7:0]       irq_pin_distribution;
	logic [1:0]       level_irq_distribution;
	logic [9:0]       ack_mask;
	// Unpacked so each per-CPU process owns its own word
	logic [31:0]      cross_cpu_request_set [2];
	logic [31:0]      cross_cpu_priority_set [2];

	// ------------------------------------------------------------
	// Access decode
	// ------------------------------------------------------------
	wire       take     = bus.req & ~bus.ack;
	wire       wr_take  = take & bus.wr;
	wire       sel_port = bus.addr == `MCID_OFS_PORT_EN;
	wire       sel_th   = bus.addr == `MCID_OFS_THERM_EN;
	wire       sel_rs   = bus.addr == `MCID_OFS_REQ_SET;
	wire       sel_rc   = bus.addr == `MCID_OFS_REQ_CLR;
	wire       sel_ps   = bus.addr == `MCID_OFS_PRIO_SET;
	wire       sel_pc   = bus.addr == `MCID_OFS_PRIO_CLR;
	wire       sel_pd   = bus.addr == `MCID_OFS_PIN_DIST;
	wire       sel_ld   = bus.addr == `MCID_OFS_LVL_DIST;
	wire       sel_af   = bus.addr == `MCID_OFS_ACK_FLAG;
	wire       sel_ac   = bus.addr == `MCID_OFS_ACK_CLR;
	wire       sel_am   = bus.addr == `MCID_OFS_ACK_MASK;
	wire       sel_st   = bus.addr == `MCID_OFS_SRC_STAT;
	wire       mapped   = sel_port | sel_th | sel_rs | sel_rc | sel_ps |
	                      sel_pc | sel_pd | sel_ld | sel_af | sel_ac |
	                      sel_am | sel_st;
	wire [1:0] cpu_hot  = bus.cpu ? 2'h2 : 2'h1;

	// ------------------------------------------------------------
	// Source gating
	// ------------------------------------------------------------
	// Both the block enable and the module's own mask must permit
	wire [7:0] next_port_req = ~port_irq_n & port_irq_enable &
	                           port_module_mask;
	wire [3:0] next_th_req   = thermal_irq & thermal_irq_enable &
	                           thermal_module_mask;
	wire [9:0] src_raw       = {level_req, irq_pin};
	wire [9:0] dist_en       = {level_irq_distribution,
	                            irq_pin_distribution};
	wire [9:0] next_dist     = src_raw & ~(ack_mask & dist_en);

	// ------------------------------------------------------------
	// Acknowledge arbitration, CPU0 first on a tie
	// ------------------------------------------------------------
	wire       ack0_dist = dist_en[cpu_ack_src[0]];
	wire       ack1_dist = dist_en[cpu_ack_src[1]];
	wire       ack0_free = ~ack_mask[cpu_ack_src[0]];
	wire       ack1_free = ~ack_mask[cpu_ack_src[1]] &
	                       ~(cpu_ack_valid[0] & ack0_dist &
	                         cpu_ack_src[0] == cpu_ack_src[1]);
	wire       win0      = ~ack0_dist | ack0_free;
	wire       win1      = ~ack1_dist | ack1_free;
	wire [9:0] grab0     = (cpu_ack_valid[0] & ack0_dist & ack0_free) ?
	                       10'(10'h001 << cpu_ack_src[0]) : 10'h000;
	wire [9:0] grab1     = (cpu_ack_valid[1] & ack1_dist & ack1_free) ?
	                       10'(10'h001 << cpu_ack_src[1]) : 10'h000;

	// Event code written to the clear register selects one source
	logic [9:0] release_hit;
	always_comb begin
		for (int i = 0; i < 10; i++) begin
			release_hit[i] = wr_take & sel_ac &
			                 bus.wdata[`MCID_EVT_MSB:0] ==
			                 (i < 8 ?
			                  14'(`MCID_EVT_PIN_BASE + 14'(i) * `MCID_EVT_STEP) :
			                  14'(`MCID_EVT_LVL_BASE +
			                      14'(i - 8) * `MCID_EVT_STEP));
		end
	end
	// A new grab in the release cycle keeps the mask set
	wire [9:0] next_mask = (ack_mask & ~release_hit) | grab0 | grab1;

	// ------------------------------------------------------------
	// Per-CPU cross requests and priorities
	// ------------------------------------------------------------
	genvar c;
	generate
		for (c = 0; c < 2; c++) begin : g_cpu
			wire wsel = wr_take & cpu_hot[c];
			wire [31:0] set_r = (wsel & sel_rs) ? bus.wdata : 32'h0000_0000;
			wire [31:0] clr_r = (wsel & sel_rc) ? bus.wdata : 32'h0000_0000;
			wire [31:0] set_p = (wsel & sel_ps) ? bus.wdata : 32'h0000_0000;
			wire [31:0] clr_p = (wsel & sel_pc) ? bus.wdata : 32'h0000_0000;
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					cross_cpu_request_set[c]  <= `MCID_RST_WORD;
					cross_cpu_priority_set[c] <= `MCID_RST_WORD;
				end else begin
					cross_cpu_request_set[c]  <= (cross_cpu_request_set[c] &
					                              ~clr_r) | set_r;
					cross_cpu_priority_set[c] <= (cross_cpu_priority_set[c] &
					                              ~clr_p) | set_p;
				end
			end
			for (genvar f = 0; f < 8; f++) begin : g_field
				// Level stays up while any bit of the field is set
				assign xcpu_irq[c][f] = |cross_cpu_request_set[c]
				                        [f*`MCID_FIELD_W +: `MCID_FIELD_W];
			end
			assign xcpu_prio[c] = cross_cpu_priority_set[c];
			assign port_src_flag[c] = {|port_req[7:4], |port_req[3:0]};
		end
	endgenerate

	// ------------------------------------------------------------
	// Configuration registers and outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			port_irq_enable        <= 8'h00;
			thermal_irq_enable     <= 4'h0;
			irq_pin_distribution   <= 8'h00;
			level_irq_distribution <= 2'h0;
		end else if (wr_take) begin
			if (sel_port)
				port_irq_enable <= bus.wdata[`MCID_PORT_EN_MSB:0];
			if (sel_th)
				thermal_irq_enable <= bus.wdata[`MCID_THERM_EN_MSB:0];
			if (sel_pd)
				irq_pin_distribution <= bus.wdata[31:`MCID_PIN_DIST_LSB];
			if (sel_ld)
				level_irq_distribution <= {bus.wdata[`MCID_LVL_DIST1_BIT],
				                           bus.wdata[`MCID_LVL_DISTRIBUTE_LINE0_BIT]};
		end
	end

	// Gated requests settle one edge after the write, before any read-back
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			port_req        <= 8'h00;
			thermal_req     <= 4'h0;
			dist_irq        <= '0;
			ack_mask        <= 10'h000;
			ack_winner_flag <= 2'h0;
		end else begin
			port_req    <= next_port_req;
			thermal_req <= next_th_req;
			dist_irq    <= {next_dist, next_dist};
			ack_mask    <= next_mask;
			if (cpu_ack_valid[0])
				ack_winner_flag[0] <= win0;
			if (cpu_ack_valid[1])
				ack_winner_flag[1] <= win1;
		end
	end

	// ------------------------------------------------------------
	// Read data and answer, one cycle after the request is taken
	// ------------------------------------------------------------
	mcid_pkg::mcid_word_t next_rdata;
	always_comb begin
		next_rdata = `MCID_RST_WORD;
		if (sel_port)
			next_rdata[`MCID_PORT_EN_MSB:0] = port_irq_enable;
		if (sel_th)
			next_rdata[`MCID_THERM_EN_MSB:0] = thermal_irq_enable;
		if (sel_rs)
			next_rdata = cross_cpu_request_set[bus.cpu];
		if (sel_ps)
			next_rdata = cross_cpu_priority_set[bus.cpu];
		if (sel_pd)
			next_rdata[31:`MCID_PIN_DIST_LSB] = irq_pin_distribution;
		if (sel_ld) begin
			next_rdata[`MCID_LVL_DISTRIBUTE_LINE0_BIT] = level_irq_distribution[0];
			next_rdata[`MCID_LVL_DIST1_BIT] = level_irq_distribution[1];
		end
		if (sel_af)
			next_rdata[0] = ack_winner_flag[bus.cpu];
		if (sel_am)
			next_rdata[9:0] = ack_mask;
		if (sel_st) begin
			next_rdata[`MCID_STAT_LO_BIT] = port_src_flag[bus.cpu][0];
			next_rdata[`MCID_STAT_HI_BIT] = port_src_flag[bus.cpu][1];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bus.ack   <= 1'b0;
			bus.err   <= 1'b0;
			bus.rdata <= `MCID_RST_WORD;
		end else begin
			bus.ack   <= take;
			bus.err   <= take & ~mapped;
			bus.rdata <= (take & ~bus.wr) ? next_rdata : `MCID_RST_WORD;
		end
	end
endmodule
`default_nettype wire

// ===== rtl/mcid_host.sv
// AXI4-Lite slave that forwards register accesses to the interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "mcid_defs.svh"
module mcid_host (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	mcid_if.ctl              bus
);
	// ------------------------------------------------------------
	// Capture of address and data, either order
	// ------------------------------------------------------------
	mcid_pkg::mcid_state_t state;
	mcid_pkg::mcid_state_t next_state;
	logic       aw_held;
	logic       w_held;
	logic [7:0] addr;
	logic [31:0] wdata;

	wire idle    = state == mcid_pkg::MCID_IDLE;
	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take  = s_axi_wvalid & s_axi_wready;
	wire ar_take = s_axi_arvalid & s_axi_arready;
	wire wr_go   = idle & aw_held & w_held;

	assign s_axi_awready = idle & ~aw_held;
	assign s_axi_wready  = idle & ~w_held;
	// Writes go first once AW is valid or either half is in
	assign s_axi_arready = idle & ~aw_held & ~w_held & ~s_axi_awvalid;

	always_comb begin
		next_state = state;
		case (state)
			mcid_pkg::MCID_IDLE:
				if (wr_go)
					next_state = mcid_pkg::MCID_WR;
				else if (ar_take)
					next_state = mcid_pkg::MCID_RD;
			mcid_pkg::MCID_WR:
				if (bus.ack)
					next_state = mcid_pkg::MCID_BRSP;
			mcid_pkg::MCID_BRSP:
				if (s_axi_bready)
					next_state = mcid_pkg::MCID_IDLE;
			mcid_pkg::MCID_RD:
				if (bus.ack)
					next_state = mcid_pkg::MCID_RRSP;
			mcid_pkg::MCID_RRSP:
				if (s_axi_rready)
					next_state = mcid_pkg::MCID_IDLE;
			default:
				next_state = mcid_pkg::MCID_IDLE;
		endcase
	end

	// ------------------------------------------------------------
	// Sequencing
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state   <= mcid_pkg::MCID_IDLE;
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			addr    <= 8'h00;
			wdata   <= `MCID_RST_WORD;
		end else begin
			state <= next_state;
			if (aw_take)
				addr <= s_axi_awaddr;
			else if (ar_take)
				addr <= s_axi_araddr;
			if (w_take)
				wdata <= s_axi_wdata;
			aw_held <= wr_go ? 1'b0 : (aw_held | aw_take);
			w_held  <= wr_go ? 1'b0 : (w_held | w_take);
		end
	end

	// Partial strobes are written whole: the request and priority registers are set/clear words
	wire unused_strb = ^s_axi_wstrb;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bus.req      <= 1'b0;
			bus.wr       <= 1'b0;
			bus.cpu      <= 1'b0;
			bus.addr     <= 6'h00;
			bus.wdata    <= `MCID_RST_WORD;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `MCID_RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp  <= `MCID_RESP_OKAY;
			s_axi_rdata  <= `MCID_RST_WORD;
		end else begin
			bus.req <= (next_state == mcid_pkg::MCID_WR |
			            next_state == mcid_pkg::MCID_RD) & ~bus.ack & ~unused_strb
			           | (next_state == mcid_pkg::MCID_WR |
			              next_state == mcid_pkg::MCID_RD) & ~bus.ack;
			if (wr_go) begin
				bus.wr    <= 1'b1;
				bus.cpu   <= addr[`MCID_AXI_CPU_BIT];
				bus.addr  <= {addr[5:2], 2'h0};
				bus.wdata <= wdata;
			end else if (ar_take) begin
				bus.wr   <= 1'b0;
				bus.cpu  <= s_axi_araddr[`MCID_AXI_CPU_BIT];
				bus.addr <= {s_axi_araddr[5:2], 2'h0};
			end
			if (state == mcid_pkg::MCID_WR && bus.ack) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= bus.err ? `MCID_RESP_SLVERR : `MCID_RESP_OKAY;
			end else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (state == mcid_pkg::MCID_RD && bus.ack) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= bus.rdata;
				s_axi_rresp  <= bus.err ? `MCID_RESP_SLVERR : `MCID_RESP_OKAY;
			end else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ===== test/mcid_asserts.sv
// Checker on the register port between host and interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "mcid_defs.svh"
module mcid_asserts (
	input wire logic                 clk,
	input wire logic                 rst_n,
	input wire logic                 req,
	input wire logic                 wr,
	input wire logic                 cpu,
	input wire logic [5:0]           addr,
	input wire mcid_pkg::mcid_word_t wdata,
	input wire logic                 ack,
	input wire logic                 err,
	input wire mcid_pkg::mcid_word_t rdata
);
	default clocking dc @(posedge clk); endclocking
	default disable iff (!rst_n);

	wire logic rd_ack;
	assign rd_ack = ack && !wr;

	// ------------------------------------------------------------
	// Handshake
	// ------------------------------------------------------------
	a_ack_next_cycle: assert property (req && !ack |=> ack)
		else $error("ack missing one cycle after request");
	a_ack_one_pulse: assert property (ack |=> !ack)
		else $error("ack held longer than one cycle");
	a_ack_has_cause: assert property (ack |-> $past(req) && !$past(ack))
		else $error("ack without a pending request");
	a_req_released: assert property (ack |=> !req)
		else $error("request not dropped after ack");
	a_req_steady: assert property (req && !ack |=> $stable({wr, cpu, addr, wdata}))
		else $error("request payload moved before ack");
	a_err_unmapped: assert property (ack && addr > 6'h2C |-> err)
		else $error("unmapped offset answered without error");
	a_err_mapped: assert property (ack && addr <= 6'h2C && addr[1:0] == 2'h0 |-> !err)
		else $error("mapped offset answered with error");

	// ------------------------------------------------------------
	// Read-back of write-only and reserved bits
	// ------------------------------------------------------------
	a_clear_reads_zero: assert property (rd_ack && (addr == `MCID_OFS_REQ_CLR || addr == `MCID_OFS_PRIO_CLR || addr == `MCID_OFS_ACK_CLR) |-> rdata == 32'h0000_0000)
		else $error("write-only register read nonzero");
	a_port_rsvd_zero: assert property (rd_ack && addr == `MCID_OFS_PORT_EN |-> rdata[31:8] == 24'h00_0000)
		else $error("port enable reserved bits set");
	a_therm_rsvd_zero: assert property (rd_ack && addr == `MCID_OFS_THERM_EN |-> rdata[31:4] == 28'h000_0000)
		else $error("thermal enable reserved bits set");
	a_pin_dist_rsvd: assert property (rd_ack && addr == `MCID_OFS_PIN_DIST |-> rdata[23:0] == 24'h00_0000)
		else $error("pin distribution reserved bits set");
	a_lvl_dist_rsvd: assert property (rd_ack && addr == `MCID_OFS_LVL_DIST |-> rdata[29:0] == 30'h0000_0000)
		else $error("level distribution reserved bits set");
	a_flag_rsvd_zero: assert property (rd_ack && addr == `MCID_OFS_ACK_FLAG |-> rdata[31:1] == 31'h0000_0000)
		else $error("ack flag reserved bits set");
	a_stat_bits_only: assert property (rd_ack && addr == `MCID_OFS_SRC_STAT |-> rdata[31:11] == 21'h00_0000 && rdata[8:0] == 9'h000)
		else $error("source status outside bits 10 and 9");
endmodule
`default_nettype wire

// ===== test/mcid_tb_top.sv
// Self-checking bench: AXI register traffic plus interrupt source stimulus
`timescale 1ns/1ps
`default_nettype none
`include "mcid_defs.svh"
module mcid_tb_top;
	logic              clk, rst_n;
	logic [7:0]        s_axi_awaddr, s_axi_araddr;
	logic [31:0]       s_axi_wdata, s_axi_rdata;
	logic [3:0]        s_axi_wstrb;
	logic [1:0]        s_axi_bresp, s_axi_rresp;
	logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic              s_axi_rvalid, s_axi_rready;
	logic [7:0]        port_irq_n, port_module_mask, irq_pin, port_req;
	logic [3:0]        thermal_irq, thermal_module_mask, thermal_req;
	logic [1:0]        level_req, cpu_ack_valid, ack_winner_flag;
	logic [1:0][3:0]   cpu_ack_src;
	logic [1:0][1:0]   port_src_flag;
	logic [1:0][7:0]   xcpu_irq;
	logic [1:0][31:0]  xcpu_prio;
	logic [1:0][9:0]   dist_irq;
	logic [31:0]       rv;
	logic [1:0]        rs;
	int                bad_count, checked;

	mcid_if bus_if ();
	mcid_host mcid_host_i (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.bus(bus_if));
	mcid_device mcid_device_i (.clk, .rst_n, .bus(bus_if), .port_irq_n,
		.port_module_mask, .thermal_irq, .thermal_module_mask, .irq_pin,
		.level_req, .cpu_ack_valid, .cpu_ack_src, .port_req, .thermal_req,
		.port_src_flag, .xcpu_irq, .xcpu_prio, .dist_irq, .ack_winner_flag);
	mcid_asserts mcid_asserts_i (.clk, .rst_n, .req(bus_if.req), .wr(bus_if.wr),
		.cpu(bus_if.cpu), .addr(bus_if.addr), .wdata(bus_if.wdata),
		.ack(bus_if.ack), .err(bus_if.err), .rdata(bus_if.rdata));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// ------------------------------------------------------------
	// Bus and compare tasks
	// ------------------------------------------------------------
	function automatic logic [7:0] ad(input logic c, input logic [5:0] o);
		return {c, 1'b0, o};
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Fresh edge on entry so a lowered ready is never re-raised in one step
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while ((s_axi_awvalid && !s_axi_awready) ||
			(s_axi_wvalid && !s_axi_wready));
		while (!s_axi_bvalid) @(posedge clk);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		while (!s_axi_rvalid) @(posedge clk);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		axi_wr(a, d, rs);
		chk(rs, `MCID_RESP_OKAY);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		axi_rd(a, rv, rs);
		chk(rs, `MCID_RESP_OKAY);
		chk(rv, e);
	endtask

	// Flag and mask settle on the edge that ends the pulse, dist_irq one later; two spare
	task automatic ack_pulse(input logic [1:0] v, input logic [3:0] s0,
		input logic [3:0] s1);
		@(posedge clk);
		cpu_ack_valid <= v;
		cpu_ack_src <= {s1, s0};
		@(posedge clk);
		cpu_ack_valid <= 2'b00;
		repeat (3) @(posedge clk);
	endtask

	task tally_and_finish;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		tally_and_finish;
	end

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		{rst_n, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		port_irq_n = 8'hFF;
		{port_module_mask, thermal_irq, thermal_module_mask} = '0;
		{irq_pin, level_req, cpu_ack_valid, cpu_ack_src} = '0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk(xcpu_irq, 16'h0000);
		for (int c = 0; c < 2; c++)
			for (int o = 0; o < 12; o++)
				rd(ad(c[0], 6'(o * 4)), 32'h0000_0000);
		// Port pins already act as inputs before any enable is set
		port_irq_n <= 8'h5A;
		port_module_mask <= 8'h3F;
		wr(ad(0, `MCID_OFS_PORT_EN), 32'hFFFF_FFFF);
		rd(ad(0, `MCID_OFS_PORT_EN), 32'h0000_00FF);
		chk(port_req, 8'h25);
		wr(ad(0, `MCID_OFS_PORT_EN), 32'h0000_000F);
		rd(ad(0, `MCID_OFS_PORT_EN), 32'h0000_000F);
		chk(port_req, 8'h05);
		chk(port_src_flag, 4'b0101);
		rd(ad(1, `MCID_OFS_SRC_STAT), 32'h0000_0200);
		port_irq_n <= 8'hFF;
		repeat (3) @(posedge clk);
		chk(port_req, 8'h00);
		thermal_irq <= 4'hC;
		thermal_module_mask <= 4'h6;
		wr(ad(0, `MCID_OFS_THERM_EN), 32'hFFFF_FFFF);
		rd(ad(0, `MCID_OFS_THERM_EN), 32'h0000_000F);
		chk(thermal_req, 4'h4);
		wr(ad(1, `MCID_OFS_REQ_SET), 32'h1000_0301);
		wr(ad(1, `MCID_OFS_REQ_SET), 32'h0000_0010);
		rd(ad(1, `MCID_OFS_REQ_SET), 32'h1000_0311);
		chk(xcpu_irq, 16'h8700);
		wr(ad(1, `MCID_OFS_REQ_CLR), 32'h0000_0201);
		rd(ad(1, `MCID_OFS_REQ_SET), 32'h1000_0110);
		chk(xcpu_irq, 16'h8600);
		rd(ad(1, `MCID_OFS_REQ_CLR), 32'h0000_0000);
		wr(ad(1, `MCID_OFS_REQ_CLR), 32'h0000_0100);
		chk(xcpu_irq, 16'h8200);
		wr(ad(0, `MCID_OFS_PRIO_SET), 32'hA5A5_0000);
		wr(ad(0, `MCID_OFS_PRIO_SET), 32'h0000_000F);
		rd(ad(0, `MCID_OFS_PRIO_SET), 32'hA5A5_000F);
		chk(xcpu_prio[0], 32'hA5A5_000F);
		chk(xcpu_prio[1], 32'h0000_0000);
		wr(ad(0, `MCID_OFS_PRIO_CLR), 32'hFFFF_0000);
		rd(ad(0, `MCID_OFS_PRIO_SET), 32'h0000_000F);
		rd(ad(0, `MCID_OFS_PRIO_CLR), 32'h0000_0000);
		wr(ad(0, `MCID_OFS_PIN_DIST), 32'hFFFF_FFFF);
		rd(ad(0, `MCID_OFS_PIN_DIST), 32'hFF00_0000);
		wr(ad(0, `MCID_OFS_LVL_DIST), 32'hFFFF_FFFF);
		rd(ad(0, `MCID_OFS_LVL_DIST), 32'hC000_0000);
		irq_pin <= 8'h04;
		level_req <= 2'b10;
		repeat (3) @(posedge clk);
		chk(dist_irq, 20'h8_1204);
		// Same-cycle grab by both CPUs: lower CPU takes it
		ack_pulse(2'b11, 4'h2, 4'h2);
		chk(ack_winner_flag, 2'b01);
		chk(dist_irq, 20'h8_0200);
		rd(ad(0, `MCID_OFS_ACK_FLAG), 32'h0000_0001);
		rd(ad(1, `MCID_OFS_ACK_FLAG), 32'h0000_0000);
		rd(ad(0, `MCID_OFS_ACK_MASK), 32'h0000_0004);
		ack_pulse(2'b10, 4'h0, 4'h9);
		chk(ack_winner_flag[1], 1'b1);
		chk(dist_irq, 20'h0_0000);
		// Late acknowledge of a source the other CPU already holds
		ack_pulse(2'h1, 4'h9, 4'h0);
		chk(ack_winner_flag, 2'h2);
		wr(ad(0, `MCID_OFS_ACK_CLR), 32'h0000_0240);
		rd(ad(0, `MCID_OFS_ACK_MASK), 32'h0000_0204);
		wr(ad(1, `MCID_OFS_ACK_CLR), 32'h0000_0280);
		rd(ad(0, `MCID_OFS_ACK_MASK), 32'h0000_0200);
		chk(dist_irq, 20'h0_1004);
		wr(ad(0, `MCID_OFS_ACK_CLR), 32'h0000_0360);
		rd(ad(0, `MCID_OFS_ACK_MASK), 32'h0000_0000);
		// Fixed distribution: acknowledger always wins, no mask taken
		wr(ad(0, `MCID_OFS_LVL_DIST), 32'h0000_0000);
		ack_pulse(2'h1, 4'h8, 4'h0);
		chk(ack_winner_flag, 2'h3);
		rd(ad(0, `MCID_OFS_ACK_MASK), 32'h0000_0000);
		axi_wr(8'h30, 32'hFFFF_FFFF, rs);
		chk(rs, `MCID_RESP_SLVERR);
		axi_rd(8'hBC, rv, rs);
		chk(rs, `MCID_RESP_SLVERR);
		rd(ad(0, `MCID_OFS_PORT_EN), 32'h0000_000F);
		tally_and_finish;
	end
endmodule
`default_nettype wire
